/* nfaoc_top.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
module nfaoc_top (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             ce_n_o,
  output logic             cle_o,
  output logic             ale_o,
  output logic             we_n_o,
  output logic             re_n_o,
  output logic             wp_n_o,
  output logic      [7:0]  dq_o,
  output logic             dq_oe_o,
  input  wire logic [7:0]  dq_i,
  input  wire logic        rb_n_i,
  input  wire logic        protect_select_pin_i
);
  import nfaoc_pkg::*;
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    T_IDLE, T_CMD, T_ADDR, T_PARAM, T_STAT_CMD, T_STAT_RD,
    T_REREAD, T_DATA_RD, T_RAW
  } nfaoc_st_t;
  nfaoc_xfer_if x ();
  nfaoc_st_t   st_q, st_d;
  nfaoc_op_t   op_q, op_d;
  nfaoc_xfer_t kind_q, kind_d;
  logic [1:0]  idx_q, idx_d;
  logic        sent_q, sent_d, req_q, req_d, hold_q, hold_d;
  logic [7:0]  wb_q, wb_d, fa_q, fa_d, raw_q, raw_d, stat_q, stat_d;
  logic [31:0] par_q, par_d, rd_q, rd_d, prd_d;
  logic [4:0]  pg_q, pg_d;
  logic        err_q, err_d, err_set, wp_q, wp_d, wpo_d;
  logic        otp_q, otp_d, prot_q, prot_d, lock_q, lock_d;
  logic [7:0]  cfg_q, cfg_d, bp_q, bp_d;
  logic        pt_q, pt_d;
  logic [4:0]  ptc_q, ptc_d;
  logic [3:0]  cnt_q [OTP_PAGES];
  logic [3:0]  cnt_d [OTP_PAGES];
  logic        rdy_d, slv_d, acc, wr, start, bad, finish;
  logic [9:0]  sync_q;
  nfaoc_op_t   new_op;
  logic [7:0]  pbyte;

  // ---------------------------------------------------------------
  // Pin sequencer and input synchroniser
  // ---------------------------------------------------------------
  nfaoc_sync #(.W(10)) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .d_i       ({protect_select_pin_i, rb_n_i, dq_i}),
    .q_o       (sync_q)
  );

  nfaoc_pin_seq u_seq (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .x         (x),
    .ce_n_o    (ce_n_o),
    .cle_o     (cle_o),
    .ale_o     (ale_o),
    .we_n_o    (we_n_o),
    .re_n_o    (re_n_o),
    .dq_o      (dq_o),
    .dq_oe_o   (dq_oe_o)
  );

  assign x.req   = req_q;
  assign x.hold  = hold_q;
  assign x.kind  = kind_q;
  assign x.wbyte = wb_q;
  assign x.dq_in = sync_q[7:0];

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  assign acc    = psel_i & penable_i & ~pready_o;
  assign wr     = psel_i & penable_i & pready_o & pwrite_i;
  assign new_op = nfaoc_op_t'(pwdata_i[2:0]);
  assign start  = wr & (paddr_i == REG_CTRL) & (new_op != OP_NONE);

  // Reserved parameter bytes go out as zero on the mode and config features.
  always_comb begin
    pbyte = par_q[idx_q*8 +: 8];
    if (fa_q == RANDOMIZER_CONFIGURATION_FEATURE) begin
      pbyte = (idx_q == 2'd0) ? (pbyte & CFG_USED_MASK) : 8'h00;
    end else if (fa_q == FA_ARRAY_MODE && idx_q != 2'd0) begin
      pbyte = 8'h00;
    end
  end

  always_comb begin
    st_d = st_q; op_d = op_q; kind_d = kind_q; idx_d = idx_q;
    sent_d = sent_q; req_d = 1'b0; hold_d = hold_q; wb_d = wb_q;
    fa_d = fa_q; raw_d = raw_q; stat_d = stat_q; par_d = par_q;
    rd_d = rd_q; pg_d = pg_q; wp_d = wp_q; wpo_d = wp_n_o;
    otp_d = otp_q; prot_d = prot_q; lock_d = lock_q;
    cfg_d = cfg_q; bp_d = bp_q; cnt_d = cnt_q;
    pt_d = pt_q; ptc_d = {ptc_q[3:0], 1'b1}; err_set = 1'b0; finish = 1'b0; bad = 1'b0;
    // The synchroniser restarts at zero, so the strap is caught only once it has filled.
    if (!ptc_q[4]) begin
      pt_d = sync_q[9];
    end
    if (wr) begin
      case (paddr_i)
        REG_CTRL:  wp_d  = pwdata_i[CTRL_WP];
        REG_FADDR: fa_d  = (st_q == T_IDLE) ? pwdata_i[7:0] : fa_q;
        REG_PARAM: par_d = (st_q == T_IDLE) ? pwdata_i : par_q;
        REG_RAW:   raw_d = (st_q == T_IDLE) ? pwdata_i[7:0] : raw_q;
        REG_PAGE:  pg_d  = (st_q == T_IDLE) ? pwdata_i[4:0] : pg_q;
        default: ;
      endcase
    end
    if (start) begin
      bad = (st_q != T_IDLE);
      // A locked or invalid protect write is never sent; only the error flag is set.
      if (new_op == OP_SET_FEAT && fa_q == FA_BLOCK_PROT &&
          (!pt_q || bp_q[BPROT_SOLID])) begin
        bad = 1'b1;
      end
      if (new_op == OP_RAW_CMD && raw_q == CMD_PROG_CONF && otp_q) begin
        if (lock_q || pg_q < OTP_FIRST_PG ||
            cnt_q[pg_q] >= OTP_MAX_PART) begin
          bad = 1'b1;
        end
      end
      if (bad) begin
        err_set = 1'b1;
      end else begin
        op_d   = new_op;
        hold_d = 1'b1;
        sent_d = 1'b0;
        idx_d  = 2'd0;
        case (new_op)
          OP_SET_FEAT, OP_GET_FEAT: st_d = T_CMD;
          OP_STATUS:                st_d = T_STAT_CMD;
          default:                  st_d = T_RAW;
        endcase
        if (new_op == OP_SET_FEAT && fa_q == FA_BLOCK_PROT) begin
          wpo_d = 1'b1;
        end
      end
    end
    if (st_q == T_IDLE) begin
      if (!start || bad) begin
        wpo_d = wp_d;
      end
    end else if (!sent_q && x.idle) begin
      req_d  = 1'b1;
      sent_d = 1'b1;
      case (st_q)
        T_CMD: begin
          kind_d = XK_CMD;
          wb_d   = (op_q == OP_SET_FEAT) ? CMD_SET_FEAT : CMD_GET_FEAT;
        end
        T_ADDR:     begin kind_d = XK_ADDR; wb_d = fa_q;       end
        T_PARAM:    begin kind_d = XK_WR;   wb_d = pbyte;      end
        T_STAT_CMD: begin kind_d = XK_CMD;  wb_d = CMD_STATUS; end
        T_STAT_RD:  begin kind_d = XK_RD;   wb_d = 8'h00;      end
        T_REREAD:   begin kind_d = XK_CMD;  wb_d = CMD_READ;   end
        T_DATA_RD:  begin kind_d = XK_RD;   wb_d = 8'h00;      end
        T_RAW: begin
          wb_d = raw_q;
          case (op_q)
            OP_RAW_CMD:  kind_d = XK_CMD;
            OP_RAW_ADDR: kind_d = XK_ADDR;
            OP_RAW_WR:   kind_d = XK_WR;
            default:     kind_d = XK_RD;
          endcase
        end
        default: kind_d = XK_CMD;
      endcase
    end else if (x.done) begin
      sent_d = 1'b0;
      case (st_q)
        T_CMD:  st_d = T_ADDR;
        T_ADDR: st_d = (op_q == OP_SET_FEAT) ? T_PARAM : T_STAT_CMD;
        T_PARAM: begin
          if (idx_q == 2'd3) begin
            st_d = T_STAT_CMD;
          end else begin
            idx_d = idx_q + 2'd1;
          end
        end
        T_STAT_CMD: st_d = T_STAT_RD;
        T_STAT_RD: begin
          // For a set or get feature, repeated read strobes keep polling while the device is busy.
          stat_d = x.rbyte;
          if (op_q == OP_STATUS) begin
            finish = 1'b1;
          end else if (x.rbyte[STAT_READY]) begin
            if (op_q == OP_GET_FEAT) begin
              st_d = T_REREAD;
            end else begin
              finish = 1'b1;
            end
          end
        end
        T_REREAD: begin
          st_d  = T_DATA_RD;
          idx_d = 2'd0;
        end
        T_DATA_RD: begin
          rd_d[idx_q*8 +: 8] = x.rbyte;
          if (idx_q == 2'd3) begin
            finish = 1'b1;
          end else begin
            idx_d = idx_q + 2'd1;
          end
        end
        T_RAW: begin
          finish = 1'b1;
          if (op_q == OP_RAW_RD) begin
            rd_d = {24'h000000, x.rbyte};
          end
          if (op_q == OP_RAW_CMD && raw_q == CMD_PROG_CONF) begin
            if (prot_q) begin
              lock_d = 1'b1;
            end else if (otp_q) begin
              cnt_d[pg_q] = cnt_q[pg_q] + 4'h1;
            end
          end
        end
        default: finish = 1'b1;
      endcase
    end
    if (finish) begin
      st_d   = T_IDLE;
      hold_d = 1'b0;
      if (op_q == OP_SET_FEAT) begin
        if (fa_q == FA_ARRAY_MODE) begin
          otp_d  = (par_q[7:0] == AOM_OTP);
          prot_d = (par_q[7:0] == AOM_PROTECT);
        end else if (fa_q == RANDOMIZER_CONFIGURATION_FEATURE) begin
          cfg_d = par_q[7:0] & CFG_USED_MASK;
        end else if (fa_q == FA_BLOCK_PROT) begin
          bp_d = par_q[7:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  always_comb begin
    rdy_d = acc;
    slv_d = 1'b0;
    prd_d = 32'h00000000;
    if (acc && !pwrite_i) begin
      case (paddr_i)
        REG_CTRL:   prd_d = {23'h000000, wp_q, 5'h00, op_q};
        REG_FADDR:  prd_d = {24'h000000, fa_q};
        REG_PARAM:  prd_d = par_q;
        REG_RDATA:  prd_d = rd_q;
        // Shadows mirror what was last written, not a device read-back.
        REG_STATUS: prd_d = {7'h00, sync_q[8], bp_q, stat_q, cfg_q[CFG_PGM_EN],
                             cfg_q[CFG_SCR_OPT], cfg_q[CFG_SCR_EN],
                             lock_q, prot_q, otp_q, err_q,
                             st_q != T_IDLE};
        REG_RAW:    prd_d = {24'h000000, raw_q};
        REG_PAGE:   prd_d = {27'h0000000, pg_q};
        default:    slv_d = 1'b1;
      endcase
    end else if (acc) begin
      case (paddr_i)
        REG_CTRL, REG_FADDR, REG_PARAM, REG_STATUS, REG_RAW, REG_PAGE: ;
        default: slv_d = 1'b1;
      endcase
    end
  end

  // A new error beats a clear arriving in the same cycle.
  assign err_d = err_set | (err_q &
                 ~(wr & (paddr_i == REG_STATUS) & pwdata_i[ST_ERR]));

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= T_IDLE; op_q <= OP_NONE; kind_q <= XK_CMD; idx_q <= 2'd0;
      sent_q <= 1'b0; req_q <= 1'b0; hold_q <= 1'b0; wb_q <= 8'h00;
      fa_q <= 8'h00; raw_q <= 8'h00; stat_q <= 8'h00;
      par_q <= 32'h00000000; rd_q <= 32'h00000000; pg_q <= 5'h00;
      err_q <= 1'b0; wp_q <= 1'b0; wp_n_o <= 1'b0;
      otp_q <= 1'b0; prot_q <= 1'b0; lock_q <= 1'b0;
      cfg_q <= RANDOMIZER_CONFIGURATION_RESET;
      bp_q  <= BPROT_RESET;
      pt_q <= 1'b0; ptc_q <= 5'h00;
      prdata_o <= 32'h00000000; pready_o <= 1'b0; pslverr_o <= 1'b0;
      for (int i = 0; i < OTP_PAGES; i++) begin
        cnt_q[i] <= 4'h0;
      end
    end else begin
      st_q <= st_d; op_q <= op_d; kind_q <= kind_d; idx_q <= idx_d;
      sent_q <= sent_d; req_q <= req_d; hold_q <= hold_d; wb_q <= wb_d;
      fa_q <= fa_d; raw_q <= raw_d; stat_q <= stat_d;
      par_q <= par_d; rd_q <= rd_d; pg_q <= pg_d;
      err_q <= err_d; wp_q <= wp_d; wp_n_o <= wpo_d;
      otp_q <= otp_d; prot_q <= prot_d; lock_q <= lock_d;
      cfg_q <= cfg_d; bp_q <= bp_d; pt_q <= pt_d; ptc_q <= ptc_d;
      prdata_o <= prd_d; pready_o <= rdy_d; pslverr_o <= slv_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : nfaoc_top

/* nfaoc_pkg.sv */
package nfaoc_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ     = 25;
  localparam int T_WR_LOW_NS = 40;
  localparam int T_RD_LOW_NS = 200;
  localparam int T_HIGH_NS   = 40;
  localparam int WR_LOW_CYC  = (T_WR_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_LOW_CYC  = (T_RD_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int HIGH_CYC    = (T_HIGH_NS * CLK_MHZ + 999) / 1000;
  // ---------------------------------------------------------------
  // Device commands, feature addresses and values
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_SET_FEAT  = 8'hef;
  localparam logic [7:0] CMD_GET_FEAT  = 8'hee;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_PROG_CONF = 8'h10;
  localparam logic [7:0] FA_RECOVERY   = 8'h89;
  localparam logic [7:0] FA_ARRAY_MODE = 8'h90;
  localparam logic [7:0] FA_BLOCK_PROT = 8'ha0;
  localparam logic [7:0] RANDOMIZER_CONFIGURATION_FEATURE = 8'hb0;
  localparam logic [7:0] RANDOMIZER_CONFIGURATION_RESET   = 8'h00;
  localparam logic [7:0] CFG_USED_MASK = 8'h07;
  localparam int         CFG_PGM_EN    = 0;
  localparam int         CFG_SCR_EN    = 1;
  localparam int         CFG_SCR_OPT   = 2;
  localparam logic [7:0] BPROT_RESET   = 8'h38;
  localparam int         BPROT_SOLID   = 0;
  localparam logic [7:0] AOM_NORMAL    = 8'h00;
  localparam logic [7:0] AOM_OTP       = 8'h01;
  localparam logic [7:0] AOM_PROTECT   = 8'h03;
  localparam int         STAT_READY    = 6;
  localparam logic [4:0] OTP_FIRST_PG  = 5'h02;
  localparam logic [3:0] OTP_MAX_PART  = 4'h8;
  localparam int         OTP_PAGES     = 32;
  // ---------------------------------------------------------------
  // Controller registers
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_FADDR  = 8'h04;
  localparam logic [7:0] REG_PARAM  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RAW    = 8'h14;
  localparam logic [7:0] REG_PAGE   = 8'h18;
  localparam int         CTRL_WP    = 8;
  localparam int         ST_ERR     = 1;

  typedef enum logic [2:0] {
    OP_NONE, OP_SET_FEAT, OP_GET_FEAT, OP_STATUS,
    OP_RAW_CMD, OP_RAW_ADDR, OP_RAW_WR, OP_RAW_RD
  } nfaoc_op_t;

  typedef enum logic [1:0] {XK_CMD, XK_ADDR, XK_WR, XK_RD} nfaoc_xfer_t;
endpackage : nfaoc_pkg

/* nfaoc_xfer_if.sv */
`timescale 1ns/10ps
interface nfaoc_xfer_if;
  import nfaoc_pkg::*;
  logic        req;
  logic        hold;
  nfaoc_xfer_t kind;
  logic [7:0]  wbyte;
  logic [7:0]  dq_in;
  logic [7:0]  rbyte;
  logic        done;
  logic        idle;
  modport ctrl (output req, hold, kind, wbyte, dq_in, input rbyte, done, idle);
  modport seq  (input req, hold, kind, wbyte, dq_in, output rbyte, done, idle);
endinterface : nfaoc_xfer_if

/* nfaoc_sync.sv */
`timescale 1ns/10ps
module nfaoc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q, s2_q, s3_q, q_d;

  // A bit moves only once the second and third stages agree.
  always_comb begin
    q_d = (s2_q & ~(s2_q ^ s3_q)) | (q_o & (s2_q ^ s3_q));
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_o  <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_o  <= q_d;
    end
  end
endmodule : nfaoc_sync

/* nfaoc_pin_seq.sv */
`timescale 1ns/10ps
module nfaoc_pin_seq (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  nfaoc_xfer_if.seq x,
  output logic       ce_n_o,
  output logic       cle_o,
  output logic       ale_o,
  output logic       we_n_o,
  output logic       re_n_o,
  output logic [7:0] dq_o,
  output logic       dq_oe_o
);
  import nfaoc_pkg::*;
  localparam logic [3:0] WR_LOW = 4'(WR_LOW_CYC);
  localparam logic [3:0] RD_LOW = 4'(RD_LOW_CYC);
  localparam logic [3:0] HIGH   = 4'(HIGH_CYC);
  typedef enum logic [1:0] {PS_IDLE, PS_LOW, PS_HIGH} nfaoc_ps_t;
  nfaoc_ps_t   st_q, st_d;
  nfaoc_xfer_t kind_q, kind_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  dq_d, rb_q, rb_d;
  logic        ce_d, cle_d, ale_d, we_d, re_d, oe_d, done_q, done_d;

  assign x.rbyte = rb_q;
  assign x.done  = done_q;
  assign x.idle  = (st_q == PS_IDLE);

  always_comb begin
    st_d = st_q; kind_d = kind_q; cnt_d = cnt_q; dq_d = dq_o; rb_d = rb_q;
    ce_d = ce_n_o; cle_d = cle_o; ale_d = ale_o; we_d = we_n_o;
    re_d = re_n_o; oe_d = dq_oe_o; done_d = 1'b0;
    case (st_q)
      PS_IDLE: begin
        ce_d = ~x.hold;
        if (x.req) begin
          kind_d = x.kind;
          ce_d   = 1'b0;
          cle_d  = (x.kind == XK_CMD);
          ale_d  = (x.kind == XK_ADDR);
          dq_d   = x.wbyte;
          oe_d   = (x.kind != XK_RD);
          we_d   = (x.kind == XK_RD);
          re_d   = (x.kind != XK_RD);
          cnt_d  = (x.kind == XK_RD) ? RD_LOW : WR_LOW;
          st_d   = PS_LOW;
        end
      end
      PS_LOW: begin
        if (cnt_q <= 4'h1) begin
          we_d  = 1'b1;
          re_d  = 1'b1;
          if (kind_q == XK_RD) begin
            rb_d = x.dq_in;
          end
          cnt_d = HIGH;
          st_d  = PS_HIGH;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      PS_HIGH: begin
        if (cnt_q <= 4'h1) begin
          cle_d  = 1'b0;
          ale_d  = 1'b0;
          oe_d   = 1'b0;
          done_d = 1'b1;
          st_d   = PS_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: st_d = PS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= PS_IDLE; kind_q <= XK_CMD; cnt_q <= 4'h0; rb_q <= 8'h00;
      ce_n_o <= 1'b1; cle_o <= 1'b0; ale_o <= 1'b0; we_n_o <= 1'b1;
      re_n_o <= 1'b1; dq_o <= 8'h00; dq_oe_o <= 1'b0; done_q <= 1'b0;
    end else begin
      st_q <= st_d; kind_q <= kind_d; cnt_q <= cnt_d; rb_q <= rb_d;
      ce_n_o <= ce_d; cle_o <= cle_d; ale_o <= ale_d; we_n_o <= we_d;
      re_n_o <= re_d; dq_o <= dq_d; dq_oe_o <= oe_d; done_q <= done_d;
    end
  end
endmodule : nfaoc_pin_seq

/* nfaoc_top_chk.sv */
`timescale 1ns/10ps
module nfaoc_top_chk (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  input  wire logic        ce_n_o,
  input  wire logic        cle_o,
  input  wire logic        ale_o,
  input  wire logic        we_n_o,
  input  wire logic        re_n_o,
  input  wire logic        wp_n_o,
  input  wire logic [7:0]  dq_o,
  input  wire logic        dq_oe_o
);
  import nfaoc_pkg::*;
  // ---------------------------------------------------------------
  // Port checks
  // ---------------------------------------------------------------
  logic [7:0] last_cmd_q;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // The last command byte tells an address byte of a set feature from a raw one.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) last_cmd_q <= 8'h00;
    else if (cle_o && !we_n_o) last_cmd_q <= dq_o;
  end
  a_ready_one_cycle: assert property (pready_o |=> !pready_o) else $error("pready held");
  a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready late");
  a_err_unmapped: assert property (pready_o && paddr_i > REG_PAGE |-> pslverr_o && prdata_o == 0)
    else $error("unmapped access answered");
  a_we_pulse: assert property ($fell(we_n_o) |=> we_n_o) else $error("we width");
  a_re_pulse: assert property ($fell(re_n_o) |-> !re_n_o [*5] ##1 re_n_o)
    else $error("re width");
  a_strobe_in_ce: assert property (!we_n_o || !re_n_o |-> !ce_n_o) else $error("strobe no ce");
  a_write_drives: assert property (!we_n_o |-> dq_oe_o && re_n_o) else $error("write not driven");
  a_read_floats: assert property (!re_n_o |-> !dq_oe_o && !cle_o && !ale_o)
    else $error("read while driving");
  a_latch_excl: assert property (!(cle_o && ale_o)) else $error("cle and ale");
  a_wp_for_prot: assert property (ale_o && !we_n_o && last_cmd_q == CMD_SET_FEAT
    && dq_o == FA_BLOCK_PROT |-> wp_n_o) else $error("wp low on protect");
  c_set_feat: cover property (cle_o && !we_n_o && dq_o == CMD_SET_FEAT);
  c_slverr: cover property (pslverr_o);
  c_read: cover property ($fell(re_n_o));
endmodule : nfaoc_top_chk
bind nfaoc_top nfaoc_top_chk chk_u (.ref_clk_i, .reset_i, .psel_i, .penable_i, .paddr_i,
  .prdata_o, .pready_o, .pslverr_o, .ce_n_o, .cle_o, .ale_o, .we_n_o, .re_n_o, .wp_n_o,
  .dq_o, .dq_oe_o);

/* nfaoc_nand_model.sv */
`timescale 1ns/10ps
module nfaoc_nand_model (
  input  wire logic       reset_i,
  input  wire logic       pin_i,
  input  wire logic       slow_i,
  input  wire logic       ce_n_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       we_n_i,
  input  wire logic       re_n_i,
  input  wire logic [7:0] dq_i,
  output logic      [7:0] dq_o,
  output logic            rb_n_o
);
  import nfaoc_pkg::*;
  // ---------------------------------------------------------------
  // Feature store
  // ---------------------------------------------------------------
  logic [7:0] fb [256];
  logic [7:0] cmd, fa, p1, out;
  logic       pin_q, busy;
  int         n, rn;
  // A released bus shows the inverse of the last byte, so stale data never matches.
  assign dq_o   = (!ce_n_i && !re_n_i) ? out : ~out;
  assign rb_n_o = ~busy;
  always @(posedge we_n_i or posedge reset_i) begin
    if (reset_i) begin
      foreach (fb[i]) fb[i] = 8'h00;
      fb[FA_BLOCK_PROT] = BPROT_RESET;
      pin_q = pin_i;
      cmd = 8'hff;
      out = 8'ha5;
      busy = 1'b0;
    end else if (!ce_n_i && cle_i) begin
      cmd = dq_i;
      n = 0;
      rn = 0;
    end else if (!ce_n_i && ale_i) begin
      fa = dq_i;
    end else if (!ce_n_i && cmd == CMD_SET_FEAT) begin
      if (n == 0) p1 = dq_i;
      n++;
      if (n == 4 && !(fa == FA_BLOCK_PROT && (!pin_q || fb[fa][BPROT_SOLID]))) begin
        fb[fa] = (fa == RANDOMIZER_CONFIGURATION_FEATURE) ? p1 & CFG_USED_MASK : p1;
      end
      if (n == 4) busy = slow_i;
    end
  end
  always @(negedge re_n_i) begin
    if (!ce_n_i && cmd == CMD_STATUS) begin
      out = busy ? 8'h00 : 8'h40;
      busy = 1'b0;
    end else if (!ce_n_i && cmd == CMD_READ) begin
      out = (rn == 0) ? fb[fa] : 8'h00;
      rn++;
    end
  end
endmodule : nfaoc_nand_model

/* test_nfaoc_top.sv */
`timescale 1ns/10ps
module test_nfaoc_top;
  import nfaoc_pkg::*;
  // ---------------------------------------------------------------
  // Bench
  // ---------------------------------------------------------------
  logic        ref_clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, rb_n_i;
  logic        ce_n_o, cle_o, ale_o, we_n_o, re_n_o, wp_n_o, dq_oe_o, pin, slow, er;
  logic [7:0]  paddr_i, dq_o, dq_i, mdl_dq;
  logic [31:0] pwdata_i, prdata_o, rd;
  int          error_cnt, tests_run, cyc;
  assign dq_i = dq_oe_o ? dq_o : mdl_dq;
  nfaoc_top dut_u (.ref_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .ce_n_o, .cle_o, .ale_o, .we_n_o, .re_n_o, .wp_n_o,
    .dq_o, .dq_oe_o, .dq_i, .rb_n_i, .protect_select_pin_i(pin));
  nfaoc_nand_model mdl_u (.reset_i, .pin_i(pin), .slow_i(slow), .ce_n_i(ce_n_o), .cle_i(cle_o),
    .ale_i(ale_o), .we_n_i(we_n_o), .re_n_i(re_n_o), .dq_i, .dq_o(mdl_dq), .rb_n_o(rb_n_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", s, e, g);
      error_cnt++;
    end
  endtask : chk
  // Pready, read data and the error flag are all taken at the edge that ends the access.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic feat(input logic [2:0] op, input logic [7:0] fa, input logic [31:0] p);
    apb(1'b1, REG_FADDR, {24'h0, fa});
    apb(1'b1, REG_PARAM, p);
    apb(1'b1, REG_CTRL, {23'h0, 1'b1, 5'h0, op});
    do apb(1'b0, REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask : feat
  task automatic t_reset();
    apb(1'b0, REG_STATUS, 32'h0);
    chk("bprot", BPROT_RESET, rd[23:16]);
    chk("cfg", 8'h00, {5'h0, rd[7:5]});
    apb(1'b0, 8'h1c, 32'h0);
    chk("slverr", 8'h01, {7'h0, er});
  endtask : t_reset
  task automatic t_cfg();
    feat(3'd1, RANDOMIZER_CONFIGURATION_FEATURE, 32'hffffffff);
    feat(3'd2, RANDOMIZER_CONFIGURATION_FEATURE, 32'h0);
    apb(1'b0, REG_RDATA, 32'h0);
    chk("cfg_p1", 8'h07, rd[7:0]);
    chk("cfg_p2_4", 8'h00, rd[31:24] | rd[23:16] | rd[15:8]);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("scr_bits", 8'h07, {5'h0, rd[7:5]});
    chk("last_stat", 8'h40, rd[15:8]);
    feat(3'd1, RANDOMIZER_CONFIGURATION_FEATURE, 32'h0);
  endtask : t_cfg
  task automatic t_recov();
    for (int m = 1; m <= 5; m++) begin
      feat(3'd1, FA_RECOVERY, 32'(m));
      feat(3'd2, FA_RECOVERY, 32'h0);
      apb(1'b0, REG_RDATA, 32'h0);
      chk("recov", 8'(m), rd[7:0]);
    end
  endtask : t_recov
  task automatic t_prot();
    feat(3'd1, FA_BLOCK_PROT, 32'h1);
    feat(3'd1, FA_BLOCK_PROT, 32'h38);
    chk("bprot_shadow", 8'h01, rd[23:16]);
    chk("prot_err", 8'h01, {7'h0, rd[1]});
    feat(3'd2, FA_BLOCK_PROT, 32'h0);
    apb(1'b0, REG_RDATA, 32'h0);
    chk("bprot_dev", 8'h01, rd[7:0]);
  endtask : t_prot
  // A slow device holds busy over the first poll, so the wait must really loop.
  task automatic t_otp();
    slow <= 1'b1;
    feat(3'd1, FA_ARRAY_MODE, {24'h0, AOM_OTP});
    chk("otp_mode", 8'h01, {7'h0, rd[2]});
    chk("rdy_stat", 8'h40, rd[15:8]);
    chk("rb_pin", 8'h01, {7'h0, rd[24]});
    slow <= 1'b0;
    apb(1'b1, REG_STATUS, 32'h2);
    apb(1'b1, REG_PAGE, 32'h1);
    apb(1'b1, REG_RAW, {24'h0, CMD_PROG_CONF});
    feat(3'd4, FA_ARRAY_MODE, {24'h0, AOM_OTP});
    chk("low_page", 8'h01, {7'h0, rd[1]});
    apb(1'b1, REG_STATUS, 32'h2);
    apb(1'b1, REG_PAGE, 32'h2);
    feat(3'd4, FA_ARRAY_MODE, {24'h0, AOM_OTP});
    chk("otp_page", 8'h00, {7'h0, rd[1]});
    feat(3'd1, FA_ARRAY_MODE, {24'h0, AOM_PROTECT});
    feat(3'd4, FA_ARRAY_MODE, {24'h0, AOM_PROTECT});
    chk("otp_lock", 8'h01, {7'h0, rd[4]});
    feat(3'd1, FA_ARRAY_MODE, {24'h0, AOM_OTP});
    feat(3'd4, FA_ARRAY_MODE, {24'h0, AOM_OTP});
    chk("locked_prog", 8'h01, {7'h0, rd[1]});
    apb(1'b1, REG_STATUS, 32'h2);
    feat(3'd1, FA_ARRAY_MODE, {24'h0, AOM_NORMAL});
    chk("normal", 8'h00, {6'h0, rd[2:1]});
  endtask : t_otp
  task automatic t_repower();
    pin <= 1'b0;
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    feat(3'd1, FA_BLOCK_PROT, 32'h0);
    chk("bprot_pin_low", BPROT_RESET, rd[23:16]);
  endtask : t_repower
  initial begin
    {reset_i, pin} = 2'b11;
    {psel_i, penable_i, pwrite_i, slow} = 4'h0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_cfg();
    t_recov();
    t_prot();
    t_otp();
    t_repower();
    wrap_up();
  end
endmodule : test_nfaoc_top
